// ### rtl/compact_isa_load_store_exec.v
/*
 Execute unit for compact register-offset halfword stores and halfword/signed loads, immediate
 word/byte/halfword transfers, stack-relative transfers, address generation
 and stack adjustment.
 Assumes the fetch stage presents one instruction with its address and a
 valid strobe, holds it while busy is high, and that memory answers a
 request with memRdValid in the request cycle or some cycles later.
*/
`timescale 1ns/1ps
`include "lsx_map.vh"
module compact_isa_load_store_exec (
	clk,
	rst_n,
	instrValid,
	instr,
	instrAddr,
	busy,
	done,
	illegal,
	memReq,
	memWrite,
	memAddr,
	memSize,
	memWrData,
	memRdData,
	memRdValid,
	flagsIn,
	flagsOut,
	flagsWrite
);
	input wire clk;
	input wire rst_n;
	input wire instrValid;
	input wire [15:0] instr;
	input wire [31:0] instrAddr;
	output reg busy;
	output reg done;
	output reg illegal;
	output reg memReq;
	output reg memWrite;
	output reg [31:0] memAddr;
	output reg [1:0] memSize;
	output reg [31:0] memWrData;
	input wire [31:0] memRdData;
	input wire memRdValid;
	input wire [3:0] flagsIn;
	output reg [3:0] flagsOut;
	output reg flagsWrite;

	localparam ST_IDLE = 5'h01;
	localparam ST_READ = 5'h02;
	localparam ST_EXEC = 5'h04;
	localparam ST_MEM = 5'h08;
	localparam ST_WAIT = 5'h10;

	// Kinds of work decoded from the instruction
	localparam K_NONE = 3'h0;
	localparam K_LOAD = 3'h1;
	localparam K_STORE = 3'h2;
	localparam K_ADDR = 3'h3;
	localparam K_SPADJ = 3'h4;

	reg rstMeta_q;
	reg rstSync_q;
	wire rstSync_n;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	assign rstSync_n = rstSync_q;

	reg [4:0] state_q;
	reg [4:0] state_d;
	reg [15:0] instr_q;
	reg [31:0] pc_q;
	reg [2:0] kind_q;
	reg [1:0] size_q;
	reg signExt_q;
	reg [1:0] addrLow_q;
	reg [1:0] waitCnt_q;

	// Decode of the latched instruction
	reg [2:0] kindDec;
	reg [1:0] sizeDec;
	reg signDec;
	reg useSp;
	reg usePc;
	reg useOfsReg;
	reg [31:0] immDec;
	reg [2:0] dstIdx;
	reg legalDec;

	always @* begin
		kindDec = K_NONE;
		sizeDec = `SZ_WORD;
		signDec = 1'b0;
		useSp = 1'b0;
		usePc = 1'b0;
		useOfsReg = 1'b0;
		immDec = 32'h00000000;
		dstIdx = instr_q[`DST_LO +: 3];
		legalDec = 1'b1;
		if (instr_q[15:12] == `FMT_REGOFS_TOP && instr_q[`ROFS_MARK_BIT]) begin
			useOfsReg = 1'b1;
			case ({instr_q[`ROFS_L_BIT], instr_q[`ROFS_B_BIT]})
				2'h0: begin
					kindDec = K_STORE;
					sizeDec = `SZ_HALF;
				end
				2'h1: begin
					kindDec = K_LOAD;
					sizeDec = `SZ_HALF;
				end
				2'h2: begin
					kindDec = K_LOAD;
					sizeDec = `SZ_BYTE;
					signDec = 1'b1;
				end
				default: begin
					kindDec = K_LOAD;
					sizeDec = `SZ_HALF;
					signDec = 1'b1;
				end
			endcase
		end else if (instr_q[15:13] == `FMT_IMM_WB_TOP) begin
			kindDec = instr_q[`WB_L_BIT] ? K_LOAD : K_STORE;
			if (instr_q[`WB_B_BIT]) begin
				sizeDec = `SZ_BYTE;
				immDec = {27'h0000000, instr_q[`OFS5_LO +: 5]};
			end else begin
				sizeDec = `SZ_WORD;
				immDec = {25'h0000000, instr_q[`OFS5_LO +: 5], 2'h0};
			end
		end else if (instr_q[15:12] == `FMT_IMM_HW_TOP) begin
			kindDec = instr_q[`HW_L_BIT] ? K_LOAD : K_STORE;
			sizeDec = `SZ_HALF;
			immDec = {26'h0000000, instr_q[`OFS5_LO +: 5], 1'b0};
		end else if (instr_q[15:12] == `FMT_SPREL_TOP) begin
			kindDec = instr_q[`HW_L_BIT] ? K_LOAD : K_STORE;
			useSp = 1'b1;
			dstIdx = instr_q[`WIDE_DST_LO +: 3];
			immDec = {22'h000000, instr_q[7:0], 2'h0};
		end else if (instr_q[15:12] == `FMT_ADDR_TOP) begin
			kindDec = K_ADDR;
			usePc = ~instr_q[`SEL_BIT];
			useSp = instr_q[`SEL_BIT];
			dstIdx = instr_q[`WIDE_DST_LO +: 3];
			immDec = {22'h000000, instr_q[7:0], 2'h0};
		end else if (instr_q[15:8] == `FMT_SPADJ_TOP) begin
			kindDec = K_SPADJ;
			useSp = 1'b1;
			immDec = {23'h000000, instr_q[6:0], 2'h0};
		end else begin
			legalDec = 1'b0;
		end
	end

	wire [31:0] baseVal;
	wire [31:0] ofsVal;
	wire [31:0] dstVal;
	wire [31:0] spVal;
	wire [31:0] extData;
	reg rfWrEn;
	reg [2:0] rfWrAddr;
	reg [31:0] rfWrData;
	reg spWrEn;
	reg [31:0] spWrData;
	reg [2:0] dstIdx_q;

	lsx_regfile regs (
		.clk(clk),
		.rstSync_n(rstSync_n),
		.rdAddrA(instr_q[`BASE_LO +: 3]),
		.rdAddrB(instr_q[`OFSR_LO +: 3]),
		.rdAddrC(dstIdx),
		.rdDataA(baseVal),
		.rdDataB(ofsVal),
		.rdDataC(dstVal),
		.spData(spVal),
		.wrEn(rfWrEn),
		.wrAddr(rfWrAddr),
		.wrData(rfWrData),
		.spWrEn(spWrEn),
		.spWrData(spWrData)
	);

	lsx_extend ext (
		.rawData(memRdData),
		.addrLow(addrLow_q),
		.size(size_q),
		.signExt(signExt_q),
		.extData(extData)
	);

	wire [31:0] pcPlus4 = instrAddr + 32'h00000004;
	wire [31:0] pcAligned = {pc_q[31:2], 1'b0, pc_q[0]};
	wire [31:0] srcVal = usePc ? pcAligned : (useSp ? spVal : baseVal);
	wire [31:0] addOperand = useOfsReg ? ofsVal : immDec;
	wire [31:0] sumVal = srcVal + addOperand;
	// sign bit picks add or subtract
	wire [31:0] spAdjVal = instr_q[`SIGN_BIT] ? (spVal - immDec) : (spVal + immDec);

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (instrValid) begin
					state_d = ST_READ;
				end
			end
			ST_READ: begin
				state_d = ST_EXEC;
			end
			ST_EXEC: begin
				if (kindDec == K_LOAD || kindDec == K_STORE) begin
					state_d = ST_MEM;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_MEM: begin
				if (memRdValid) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (waitCnt_q == 2'h0) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @* begin
		rfWrEn = 1'b0;
		rfWrAddr = dstIdx_q;
		rfWrData = 32'h00000000;
		spWrEn = 1'b0;
		spWrData = spAdjVal;
		if (state_q == ST_EXEC && kindDec == K_ADDR) begin
			rfWrEn = 1'b1;
			rfWrAddr = dstIdx;
			rfWrData = sumVal;
		end
		if (state_q == ST_EXEC && kindDec == K_SPADJ) begin
			spWrEn = 1'b1;
		end
		if (state_q == ST_MEM && memRdValid && kind_q == K_LOAD) begin
			rfWrEn = 1'b1;
			rfWrData = extData;
		end
	end

	always @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_q <= ST_IDLE;
			instr_q <= 16'h0000;
			pc_q <= 32'h00000000;
			kind_q <= K_NONE;
			size_q <= `SZ_WORD;
			signExt_q <= 1'b0;
			addrLow_q <= 2'h0;
			waitCnt_q <= 2'h0;
			dstIdx_q <= 3'h0;
			busy <= 1'b0;
			done <= 1'b0;
			illegal <= 1'b0;
			memReq <= 1'b0;
			memWrite <= 1'b0;
			memAddr <= 32'h00000000;
			memSize <= `SZ_WORD;
			memWrData <= 32'h00000000;
			flagsOut <= 4'h0;
			flagsWrite <= 1'b0;
		end else begin
			state_q <= state_d;
			done <= 1'b0;
			illegal <= 1'b0;
			memReq <= 1'b0;
			flagsWrite <= 1'b0;
			flagsOut <= flagsIn;
			if (state_q == ST_IDLE && instrValid) begin
				instr_q <= instr;
				pc_q <= pcPlus4;
				busy <= 1'b1;
			end
			if (state_q == ST_EXEC) begin
				kind_q <= kindDec;
				size_q <= sizeDec;
				signExt_q <= signDec;
				addrLow_q <= sumVal[1:0];
				dstIdx_q <= dstIdx;
				if (kindDec == K_LOAD || kindDec == K_STORE) begin
					memReq <= 1'b1;
					memWrite <= (kindDec == K_STORE);
					memAddr <= sumVal;
					memSize <= sizeDec;
					// Byte and halfword store data replicated across lanes so any naturally aligned lane works; word data goes out as is
					case (sizeDec)
						`SZ_BYTE: memWrData <= {4{dstVal[7:0]}};
						`SZ_HALF: memWrData <= {2{dstVal[15:0]}};
						default: memWrData <= dstVal;
					endcase
					waitCnt_q <= (kindDec == K_LOAD) ? `CYC_LOAD - `CYC_STORE : 2'h0;
				end else begin
					busy <= 1'b0;
					done <= 1'b1;
					illegal <= ~legalDec;
				end
			end
			if (state_q == ST_WAIT) begin
				if (waitCnt_q == 2'h0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					waitCnt_q <= waitCnt_q - 2'h1;
				end
			end
		end
	end
endmodule

// ### pkg/lsx_map.vh
/*
 Constants for the compact load/store/address execute unit: opcode fields,
 format codes, transfer sizes and timing counts.
 Assumes inclusion by bare name from the rtl files.
*/
`ifndef LSX_MAP_VH
`define LSX_MAP_VH

// Format selector patterns on instruction bits 15:12 (15:13 and 15:8 where needed)
`define FMT_REGOFS_TOP 4'h5
`define FMT_IMM_WB_TOP 3'h3
`define FMT_IMM_HW_TOP 4'h8
`define FMT_SPREL_TOP 4'h9
`define FMT_ADDR_TOP 4'hA
`define FMT_SPADJ_TOP 8'hB0

// Field positions
`define DST_LO 0
`define BASE_LO 3
`define OFSR_LO 6
`define OFS5_LO 6
`define WB_B_BIT 12
`define WB_L_BIT 11
`define HW_L_BIT 11
`define ROFS_L_BIT 11
`define ROFS_B_BIT 10
`define ROFS_MARK_BIT 9
`define SEL_BIT 11
`define SIGN_BIT 7
`define WIDE_DST_LO 8

// Transfer size codes
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2

// Register index of the stack pointer
`define SP_INDEX 4'hD

// Pipeline timing: cycles for an address/arith op and for a memory op
`define CYC_ALU 2'h1
`define CYC_LOAD 2'h3
`define CYC_STORE 2'h2

`endif

// ### rtl/lsx_regfile.v
/*
 Low general register file (eight words) plus stack pointer, with
 registered read data.
 Assumes one general write port plus a stack pointer write port, and synchronous reads issued one cycle ahead.
*/
`timescale 1ns/1ps
module lsx_regfile (
	clk,
	rstSync_n,
	rdAddrA,
	rdAddrB,
	rdAddrC,
	rdDataA,
	rdDataB,
	rdDataC,
	spData,
	wrEn,
	wrAddr,
	wrData,
	spWrEn,
	spWrData
);
	input wire clk;
	input wire rstSync_n;
	input wire [2:0] rdAddrA;
	input wire [2:0] rdAddrB;
	input wire [2:0] rdAddrC;
	output reg [31:0] rdDataA;
	output reg [31:0] rdDataB;
	output reg [31:0] rdDataC;
	output reg [31:0] spData;
	input wire wrEn;
	input wire [2:0] wrAddr;
	input wire [31:0] wrData;
	input wire spWrEn;
	input wire [31:0] spWrData;

	reg [31:0] mem [0:7];
	integer i;

	always @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			for (i = 0; i < 8; i = i + 1) begin
				mem[i] <= 32'h00000000;
			end
			spData <= 32'h00000000;
			rdDataA <= 32'h00000000;
			rdDataB <= 32'h00000000;
			rdDataC <= 32'h00000000;
		end else begin
			if (wrEn) begin
				mem[wrAddr] <= wrData;
			end
			if (spWrEn) begin
				spData <= spWrData;
			end
			rdDataA <= mem[rdAddrA];
			rdDataB <= mem[rdAddrB];
			rdDataC <= mem[rdAddrC];
		end
	end
endmodule

// ### rtl/lsx_extend.v
/*
 Load data extender: picks the addressed byte or halfword out of a bus
 word and zero or sign extends it.
 Assumes little-endian lane order on the memory read bus.
*/
`timescale 1ns/1ps
`include "lsx_map.vh"
module lsx_extend (
	rawData,
	addrLow,
	size,
	signExt,
	extData
);
	input wire [31:0] rawData;
	input wire [1:0] addrLow;
	input wire [1:0] size;
	input wire signExt;
	output reg [31:0] extData;

	reg [7:0] byteVal;
	reg [15:0] halfVal;

	always @* begin
		byteVal = rawData[8*addrLow +: 8];
		halfVal = addrLow[1] ? rawData[31:16] : rawData[15:0];
		case (size)
			`SZ_BYTE: begin
				extData = {{24{signExt & byteVal[7]}}, byteVal};
			end
			`SZ_HALF: begin
				extData = {{16{signExt & halfVal[15]}}, halfVal};
			end
			default: begin
				extData = rawData;
			end
		endcase
	end
endmodule

// ### bench/lsx_exec_checker.sv
/*
 Checker for the compact execute unit: timing, transfer sizes and flag handling.
 Assumes binding to the top module and sight of its ports only.
*/
`timescale 1ns/1ps
`include "lsx_map.vh"
module lsx_exec_checker (
	input wire clk,
	input wire rst_n,
	input wire instrValid,
	input wire [15:0] instr,
	input wire busy,
	input wire done,
	input wire illegal,
	input wire memReq,
	input wire memWrite,
	input wire [1:0] memSize,
	input wire memRdValid,
	input wire [3:0] flagsIn,
	input wire [3:0] flagsOut,
	input wire flagsWrite
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire take = instrValid && !busy;
	wire [1:0] lb = instr[11:10];
	wire aluFmt = instr[15:12] == `FMT_ADDR_TOP || instr[15:8] == `FMT_SPADJ_TOP;
	wire memFmt = (instr[15:12] == `FMT_REGOFS_TOP && instr[9]) || instr[15:13] == `FMT_IMM_WB_TOP
		|| instr[15:12] == `FMT_IMM_HW_TOP || instr[15:12] == `FMT_SPREL_TOP;

	a_flags_kept: assert property (!flagsWrite)
		else $error("flags written");
	// Internal reset trails the port by two flops, so wait before comparing
	a_flags_pass: assert property ($past(rst_n, 3) |-> flagsOut == $past(flagsIn))
		else $error("flags not passed through");
	a_alu_time: assert property (take && aluFmt |-> ##3 done)
		else $error("address op latency wrong");
	a_mem_issue: assert property (take && memFmt |-> ##3 memReq)
		else $error("memory request latency wrong");
	// Answer may come in the request cycle; done follows by the load or store padding
	a_store_ack: assert property (memReq && memWrite && memRdValid |-> ##2 done)
		else $error("store completion late");
	a_load_ack: assert property (memReq && !memWrite && memRdValid |-> ##3 done)
		else $error("load completion timing wrong");
	a_half_size: assert property (memReq && instr[15:12] == `FMT_IMM_HW_TOP |-> memSize == `SZ_HALF)
		else $error("halfword size wrong");
	a_stack_word: assert property (memReq && instr[15:12] == `FMT_SPREL_TOP
		|-> memSize == `SZ_WORD && memWrite == !instr[11])
		else $error("stack transfer wrong");
	a_regofs_kind: assert property (memReq && instr[15:12] == `FMT_REGOFS_TOP
		|-> memWrite == (lb == 2'h0) && memSize == (lb == 2'h2 ? `SZ_BYTE : `SZ_HALF))
		else $error("register offset transfer wrong");
	a_req_pulse: assert property (memReq |=> !memReq)
		else $error("request longer than a cycle");
	a_illegal_done: assert property (illegal |-> done && !memReq)
		else $error("illegal without done");
endmodule
bind compact_isa_load_store_exec lsx_exec_checker lsx_exec_checker_i (.clk(clk), .rst_n(rst_n),
	.instrValid(instrValid), .instr(instr), .busy(busy), .done(done), .illegal(illegal),
	.memReq(memReq), .memWrite(memWrite), .memSize(memSize), .memRdValid(memRdValid),
	.flagsIn(flagsIn), .flagsOut(flagsOut), .flagsWrite(flagsWrite));

// ### bench/test_compact_isa_load_store_exec.sv
/*
 Self-checking bench for the compact execute unit.
 Plays fetch stage and memory itself; registers are set and read back through loads and stores.
*/
`timescale 1ns/1ps
`include "lsx_map.vh"
`define CHK(a, b) \
	begin \
		num_checks++; \
		if ((a) !== (b)) begin \
			error_cnt++; \
			$display("Error at %0t: got %h expected %h", $time, a, b); \
		end \
	end
module test_compact_isa_load_store_exec;
	logic clk = 0;
	logic rst_n = 0;
	logic instrValid = 0;
	logic memRdValid = 0;
	logic [15:0] instr = 16'h0000;
	logic [31:0] instrAddr = 32'h0;
	logic [31:0] memRdData = 32'h0;
	logic [3:0] flagsIn = 4'h0;
	wire busy, done, illegal, memReq, memWrite, flagsWrite;
	wire [31:0] memAddr, memWrData;
	wire [1:0] memSize;
	wire [3:0] flagsOut;
	logic [31:0] wd, ad;
	logic [1:0] sz;
	int error_cnt = 0;
	int num_checks = 0;
	int cycles = 0;

	compact_isa_load_store_exec compact_isa_load_store_exec_i (.clk(clk), .rst_n(rst_n),
		.instrValid(instrValid), .instr(instr), .instrAddr(instrAddr), .busy(busy),
		.done(done), .illegal(illegal), .memReq(memReq), .memWrite(memWrite),
		.memAddr(memAddr), .memSize(memSize), .memWrData(memWrData), .memRdData(memRdData),
		.memRdValid(memRdValid), .flagsIn(flagsIn), .flagsOut(flagsOut), .flagsWrite(flagsWrite));

	initial forever #12.5 clk = ~clk;
	always @(negedge clk) flagsIn <= flagsIn + 4'h3;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("num_checks %0d error_cnt %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// kind: 0 address op, 1 store, 2 load, 3 illegal; entered at a falling edge
	task automatic exec(input logic [15:0] ins, input logic [31:0] pc, input logic [31:0] rd,
		input int kind);
		int cyc;
		logic sawReq;
		cyc = 1;
		sawReq = 0;
		instr = ins;
		instrAddr = pc;
		instrValid = 1;
		@(negedge clk);
		instrValid = 0;
		while (done !== 1'b1 && cyc < 40) begin
			if (memReq === 1'b1) begin
				sawReq = 1;
				wd = memWrData;
				ad = memAddr;
				sz = memSize;
				`CHK(memWrite, kind == 1)
				memRdValid = 1;
				memRdData = rd;
			end else begin
				memRdValid = 0;
				// Read bus carries junk outside the answer cycle
				memRdData = ~memRdData;
			end
			@(negedge clk);
			cyc++;
		end
		memRdValid = 0;
		`CHK(illegal, kind == 3)
		`CHK(sawReq, kind == 1 || kind == 2)
		// Edges from take to done seen, with the answer in the request cycle
		`CHK(cyc, kind == 1 ? 3 + `CYC_STORE : kind == 2 ? 3 + `CYC_LOAD : 2 + `CYC_ALU)
	endtask

	task automatic setReg(input logic [2:0] r, input logic [31:0] v);
		exec(16'h6800 | {13'h0, r}, 32'h0, v, 2);
	endtask

	task automatic chkReg(input logic [2:0] r, input logic [31:0] v);
		exec(16'h6000 | {13'h0, r}, 32'h0, 32'h0, 1);
		`CHK(wd, v)
	endtask

	task automatic chkMem(input logic [31:0] a, input logic [1:0] s, input logic [31:0] d,
		input logic st);
		`CHK(ad, a)
		`CHK(sz, s)
		if (st)
			`CHK(wd, d)
	endtask

	task automatic t_regofs();
		setReg(3'h1, 32'h0000_1000);
		setReg(3'h2, 32'h0000_0022);
		setReg(3'h3, 32'h1234_ABCD);
		exec(16'h528B, 32'h0, 32'h0, 1);
		chkMem(32'h0000_1022, `SZ_HALF, 32'hABCD_ABCD, 1);
		exec(16'h568C, 32'h0, 32'h8765_4321, 2);
		chkMem(32'h0000_1022, `SZ_HALF, 32'h0, 0);
		exec(16'h5A8D, 32'h0, 32'h12F0_3456, 2);
		chkMem(32'h0000_1022, `SZ_BYTE, 32'h0, 0);
		exec(16'h5E8E, 32'h0, 32'h9ABC_0000, 2);
		chkReg(3'h4, 32'h0000_8765);
		chkReg(3'h5, 32'hFFFF_FFF0);
		chkReg(3'h6, 32'hFFFF_9ABC);
		$display("register offset test done");
	endtask

	task automatic t_immwb();
		exec(16'h67CB, 32'h0, 32'h0, 1);
		chkMem(32'h0000_107C, `SZ_WORD, 32'h1234_ABCD, 1);
		exec(16'h694C, 32'h0, 32'hCAFE_F00D, 2);
		chkMem(32'h0000_1014, `SZ_WORD, 32'h0, 0);
		exec(16'h77CB, 32'h0, 32'h0, 1);
		chkMem(32'h0000_101F, `SZ_BYTE, 32'hCDCD_CDCD, 1);
		exec(16'h78CD, 32'h0, 32'h8100_0000, 2);
		chkMem(32'h0000_1003, `SZ_BYTE, 32'h0, 0);
		chkReg(3'h4, 32'hCAFE_F00D);
		chkReg(3'h5, 32'h0000_0081);
		$display("immediate word and byte test done");
	endtask

	task automatic t_immhw();
		exec(16'h87CB, 32'h0, 32'h0, 1);
		chkMem(32'h0000_103E, `SZ_HALF, 32'hABCD_ABCD, 1);
		exec(16'h884E, 32'h0, 32'hFEDC_1111, 2);
		chkMem(32'h0000_1002, `SZ_HALF, 32'h0, 0);
		chkReg(3'h6, 32'h0000_FEDC);
		$display("immediate halfword test done");
	endtask

	task automatic t_stack();
		exec(16'hB07F, 32'h0, 32'h0, 0);
		exec(16'hB07F, 32'h0, 32'h0, 0);
		exec(16'hB081, 32'h0, 32'h0, 0);
		exec(16'h93FF, 32'h0, 32'h0, 1);
		chkMem(32'h0000_07F0, `SZ_WORD, 32'h1234_ABCD, 1);
		exec(16'h9F00, 32'h0, 32'h5555_AAAA, 2);
		chkMem(32'h0000_03F4, `SZ_WORD, 32'h0, 0);
		chkReg(3'h7, 32'h5555_AAAA);
		exec(16'hAAFF, 32'h0, 32'h0, 0);
		chkReg(3'h2, 32'h0000_07F0);
		exec(16'hA101, 32'h0000_1002, 32'h0, 0);
		chkReg(3'h1, 32'h0000_1008);
		$display("stack and address test done");
	endtask

	task automatic t_illegal();
		exec(16'h5000, 32'h0, 32'h0, 3);
		exec(16'h4000, 32'h0, 32'h0, 3);
		chkReg(3'h3, 32'h1234_ABCD);
		$display("illegal test done");
	endtask

	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1;
		repeat (4) @(negedge clk);
		t_regofs();
		t_immwb();
		t_immhw();
		t_stack();
		t_illegal();
		complete_run();
	end
endmodule
